// *** hw/rid_pkg.sv ***
package rid_pkg;
    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [5:0] ADDR_CTRL = 6'h00;
    localparam logic [5:0] ADDR_STAT = 6'h04;
    localparam logic [5:0] ADDR_IRQ = 6'h08;
    localparam logic [5:0] ADDR_MASK = 6'h0c;
    localparam logic [5:0] ADDR_NAME_LEN = 6'h10;
    localparam logic [5:0] ADDR_SEG = 6'h14;

    // ctrl fields
    localparam int CTRL_ILOCK_EN = 0;
    localparam int CTRL_PRESS_ONLY = 1;
    localparam int CTRL_ROTATE = 2;
    localparam int CTRL_LARGE_FIELD = 3;
    localparam int CTRL_REDUCED = 4;
    localparam int CTRL_TEST_MODE = 5;
    localparam int CTRL_SENDER = 6;
    localparam int CTRL_CODE_LO = 7;
    localparam logic [8:0] CTRL_RESET = 9'h001;

    // irq fields
    localparam int IRQ_BREAK = 0;
    localparam int IRQ_FAULT = 1;
    localparam int IRQ_RESET = 2;
    localparam int IRQ_NAME_TRUNC = 3;
    localparam int IRQ_W = 4;

    localparam logic [4:0] NAME_MAX = 5'h16;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ = 100;
    localparam int DEBOUNCE_MS = 10;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * 1000 * CLK_MHZ;
    localparam int STARTUP_MS = 2000;
    localparam int STARTUP_CYC = STARTUP_MS * 1000 * CLK_MHZ;

    // ************************************************************
    // seven-segment glyphs, bit order gfedcba
    // ************************************************************
    localparam logic [6:0] SEG_BLANK = 7'h00;
    localparam logic [6:0] SEG_U = 7'h3e;
    localparam logic [6:0] SEG_C1 = 7'h06;
    localparam logic [6:0] SEG_C2 = 7'h5b;
    localparam logic [6:0] SEG_H = 7'h76;
    localparam logic [6:0] SEG_R = 7'h50;
    localparam logic [6:0] SEG_ZERO = 7'h3f;
    localparam logic [6:0] SEG_ONE = 7'h06;
    localparam logic [6:0] SEG_TWO = 7'h5b;
    localparam logic [1:0] CODE_NONE = 2'h0;
    localparam logic [1:0] CODE_1 = 2'h1;
    localparam logic [1:0] CODE_2 = 2'h2;

    typedef enum logic [1:0] {ST_OFF, ST_WAIT, ST_ON} rid_state_t;
endpackage

// *** hw/rid_debounce.sv ***
`timescale 1ns/10ps
module rid_debounce #(
    parameter int CYCLES = 1000000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic raw,
    output logic clean
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic stable;
        logic [31:0] cnt;
    } rid_db_t;

    rid_db_t q, d;

    always_comb
    begin
        d = q;
        d.s1 = raw;
        d.s2 = q.s1;
        if (q.s2 == q.stable)
        begin
            d.cnt = 32'h0;
        end
        else if (q.cnt >= 32'(CYCLES - 1))
        begin
            d.stable = q.s2;
            d.cnt = 32'h0;
        end
        else
        begin
            d.cnt = q.cnt + 32'h1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign clean = q.stable;
endmodule

// *** hw/rid_top.sv ***
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// How it works
// - broken beam drops outputs; interlock holds them
// - fault also drops outputs; interlock holds them until reset
// - interlock enable bit; off means follow beam
// - press-only or press-and-release reset mode
// - reset-required lamp lit while waiting
// - red lamp while outputs off
// - green lamp only while outputs on
// - beam coding shown only after power-up
// - large field code shown after power-up
// - reduced resolution or blanking code shown
// - alignment quality codes on poor alignment
// - sender shows test mode code
// - rotate bit; point lit only unrotated
// - names beyond 22 characters are truncated
// - accepted reset re-enables outputs, green
module rid_top #(
    parameter int DEBOUNCE_CYC = rid_pkg::DEBOUNCE_CYC,
    parameter int STARTUP_CYC = rid_pkg::STARTUP_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic beam_clear,
    input wire logic fault,
    input wire logic reset_button,
    input wire logic [1:0] align_level,
    output logic switch_out,
    output logic reset_lamp,
    output logic led_red,
    output logic led_green,
    output logic [6:0] seg,
    output logic seg_dp,
    output logic irq
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic aw_ok;
        logic [5:0] awaddr;
        logic w_ok;
        logic [31:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [8:0] ctrl;
        logic [rid_pkg::IRQ_W-1:0] sts;
        logic [rid_pkg::IRQ_W-1:0] mask;
        logic [4:0] name_len;
        rid_pkg::rid_state_t st;
        logic btn_prev;
        logic armed;
        logic [31:0] up_cnt;
        logic startup;
        logic b1, b2, f1, f2;
        logic [1:0] a1, a2;
        logic sw, lamp, red, green, dp, irq;
        logic awrdy, wrdy, arrdy;
        logic [6:0] seg;
    } rid_top_t;

    rid_top_t q, d;
    logic btn;
    logic press, release_ev, accept, trunc_ev;
    logic [6:0] glyph;

    // sync + debounce before any edge logic
    rid_debounce #(
        .CYCLES(DEBOUNCE_CYC)
    ) u_db (
        .aclk(aclk),
        .aresetn(aresetn),
        .raw(reset_button),
        .clean(btn)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        d = q;
        d.b1 = beam_clear;
        d.b2 = q.b1;
        d.f1 = fault;
        d.f2 = q.f1;
        d.a1 = align_level;
        d.a2 = q.a1;
        d.btn_prev = btn;
        press = btn && !q.btn_prev;
        release_ev = !btn && q.btn_prev;
        trunc_ev = 1'b0;

        // bus write: address and data in either order
        if (s_axi_awvalid && !q.aw_ok)
        begin
            d.aw_ok = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_ok)
        begin
            d.w_ok = 1'b1;
            d.wdata = s_axi_wdata;
        end
        if (q.aw_ok && q.w_ok && !q.bvalid)
        begin
            d.aw_ok = 1'b0;
            d.w_ok = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = 2'h0;
            case (q.awaddr)
                rid_pkg::ADDR_CTRL:
                    d.ctrl = q.wdata[8:0];
                rid_pkg::ADDR_MASK:
                    d.mask = q.wdata[rid_pkg::IRQ_W-1:0];
                rid_pkg::ADDR_NAME_LEN:
                begin
                    // over-long names clamp and flag
                    trunc_ev = q.wdata > 32'(rid_pkg::NAME_MAX);
                    d.name_len = trunc_ev ? rid_pkg::NAME_MAX : q.wdata[4:0];
                end
                rid_pkg::ADDR_STAT, rid_pkg::ADDR_IRQ, rid_pkg::ADDR_SEG:
                    d.bresp = 2'h0;
                default:
                    d.bresp = 2'h2;
            endcase
        end
        d.bvalid = d.bvalid && !(q.bvalid && s_axi_bready);

        // bus read; read of irq status clears it (sets below win)
        if (s_axi_arvalid && !q.rvalid)
        begin
            d.rvalid = 1'b1;
            d.rresp = 2'h0;
            d.rdata = 32'h0;
            case (s_axi_araddr)
                rid_pkg::ADDR_CTRL:
                    d.rdata = {23'h0, q.ctrl};
                rid_pkg::ADDR_STAT:
                    d.rdata = {27'h0, q.st, q.startup, q.sw, q.lamp};
                rid_pkg::ADDR_IRQ:
                begin
                    d.rdata = {28'h0, q.sts};
                    d.sts = '0;
                end
                rid_pkg::ADDR_MASK:
                    d.rdata = {28'h0, q.mask};
                rid_pkg::ADDR_NAME_LEN:
                    d.rdata = {27'h0, q.name_len};
                rid_pkg::ADDR_SEG:
                    d.rdata = {24'h0, q.dp, q.seg};
                default:
                    d.rresp = 2'h2;
            endcase
        end
        d.rvalid = d.rvalid && !(q.rvalid && s_axi_rready);
        // a truncation in a read-clear cycle still wins
        d.sts[rid_pkg::IRQ_NAME_TRUNC] |= trunc_ev;

        // power-up display window
        d.startup = q.startup && (q.up_cnt < 32'(STARTUP_CYC - 1));
        d.up_cnt = q.up_cnt + 32'(d.startup);

        // ************************************************************
        // interlock
        // ************************************************************
        accept = 1'b0;
        case (q.st)
            rid_pkg::ST_ON:
            begin
                if (!q.b2 || q.f2)
                begin
                    d.st = q.ctrl[rid_pkg::CTRL_ILOCK_EN] ?
                        rid_pkg::ST_WAIT : rid_pkg::ST_OFF;
                    d.sts[rid_pkg::IRQ_BREAK] |= !q.b2;
                    d.sts[rid_pkg::IRQ_FAULT] |= q.f2;
                end
            end
            rid_pkg::ST_OFF:
            begin
                // external interlock does the restart
                if (q.b2 && !q.f2)
                begin
                    d.st = q.ctrl[rid_pkg::CTRL_ILOCK_EN] ?
                        rid_pkg::ST_WAIT : rid_pkg::ST_ON;
                end
            end
            rid_pkg::ST_WAIT:
            begin
                if (q.ctrl[rid_pkg::CTRL_PRESS_ONLY])
                begin
                    accept = press;
                end
                else
                begin
                    d.armed = q.armed || press;
                    accept = release_ev && q.armed;
                end
                if (!q.ctrl[rid_pkg::CTRL_ILOCK_EN])
                begin
                    d.st = rid_pkg::ST_OFF;
                    d.armed = 1'b0;
                end
                else if (accept && q.b2 && !q.f2)
                begin
                    d.st = rid_pkg::ST_ON;
                    d.armed = 1'b0;
                    d.sts[rid_pkg::IRQ_RESET] = 1'b1;
                end
            end
            default:
                d.st = rid_pkg::ST_OFF;
        endcase
        if (q.st != rid_pkg::ST_ON && q.st == d.st
            && (!q.b2 || q.f2))
        begin
            d.armed = 1'b0;
        end

        // ************************************************************
        // indicators, from next state so they move with the state
        // ************************************************************
        d.sw = (d.st == rid_pkg::ST_ON);
        d.lamp = (d.st == rid_pkg::ST_WAIT);
        d.red = (d.st != rid_pkg::ST_ON);
        d.green = (d.st == rid_pkg::ST_ON) && !q.f2;
        glyph = rid_pkg::SEG_BLANK;
        if (q.ctrl[rid_pkg::CTRL_SENDER] && q.ctrl[rid_pkg::CTRL_TEST_MODE])
        begin
            glyph = rid_pkg::SEG_ZERO;
        end
        else if (q.startup && q.ctrl[rid_pkg::CTRL_LARGE_FIELD]
                 && !q.ctrl[rid_pkg::CTRL_SENDER])
        begin
            glyph = rid_pkg::SEG_H;
        end
        else if (q.startup)
        begin
            case (q.ctrl[rid_pkg::CTRL_CODE_LO +: 2])
                rid_pkg::CODE_1: glyph = rid_pkg::SEG_C1;
                rid_pkg::CODE_2: glyph = rid_pkg::SEG_C2;
                default: glyph = rid_pkg::SEG_U;
            endcase
        end
        else if (!q.ctrl[rid_pkg::CTRL_SENDER] && q.a2 != 2'h0)
        begin
            // weaker signal, lower digit
            case (q.a2)
                2'h1: glyph = rid_pkg::SEG_TWO;
                2'h2: glyph = rid_pkg::SEG_ONE;
                default: glyph = rid_pkg::SEG_ZERO;
            endcase
        end
        else if (!q.ctrl[rid_pkg::CTRL_SENDER]
                 && q.ctrl[rid_pkg::CTRL_REDUCED])
        begin
            glyph = rid_pkg::SEG_R;
        end
        // rotation: swap a<->d, b<->e, c<->f, g stays
        if (q.ctrl[rid_pkg::CTRL_ROTATE])
        begin
            d.seg = {glyph[6], glyph[2], glyph[1], glyph[0],
                     glyph[5], glyph[4], glyph[3]};
        end
        else
        begin
            d.seg = glyph;
        end
        d.dp = !q.ctrl[rid_pkg::CTRL_ROTATE];
        d.irq = |(d.sts & q.mask);
        d.awrdy = !d.aw_ok;
        d.wrdy = !d.w_ok;
        d.arrdy = !d.rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.ctrl <= rid_pkg::CTRL_RESET;
            q.awrdy <= 1'b1;
            q.wrdy <= 1'b1;
            q.arrdy <= 1'b1;
            q.startup <= 1'b1;
            q.red <= 1'b1;
            q.dp <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign s_axi_awready = q.awrdy;
    assign s_axi_wready = q.wrdy;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arrdy;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign switch_out = q.sw;
    assign reset_lamp = q.lamp;
    assign led_red = q.red;
    assign led_green = q.green;
    assign seg = q.seg;
    assign seg_dp = q.dp;
    assign irq = q.irq;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_beam_lost;
        q.sw && !q.b2;
    endsequence

    a_break_drops: assert property (
        s_beam_lost |=> !q.sw ##0 !switch_out)
    else $error("outputs stayed on after beam break");
    a_hold_wait: assert property (
        q.st == rid_pkg::ST_WAIT && !accept |=> !q.sw)
    else $error("outputs came on without reset");
    a_auto_off: assert property (
        q.st == rid_pkg::ST_OFF && !q.ctrl[rid_pkg::CTRL_ILOCK_EN]
        && q.b2 && !q.f2 |=> q.st == rid_pkg::ST_ON)
    else $error("no automatic restart with interlock off");
    a_lamp_wait: assert property (
        reset_lamp == (q.st == rid_pkg::ST_WAIT))
    else $error("reset lamp wrong");
    a_red_off: assert property (led_red == !switch_out)
    else $error("red lamp wrong");
    a_green_on: assert property (led_green |-> switch_out)
    else $error("green without outputs on");
    a_dp_rot: assert property (
        ##1 seg_dp == !$past(q.ctrl[rid_pkg::CTRL_ROTATE]))
    else $error("point wrong for rotation");
    a_name_clamp: assert property (
        q.name_len <= rid_pkg::NAME_MAX)
    else $error("name length over limit");
    a_reset_on: assert property (
        q.st == rid_pkg::ST_WAIT && accept && q.b2 && !q.f2
        && q.ctrl[rid_pkg::CTRL_ILOCK_EN] |=> switch_out && led_green)
    else $error("accepted reset did not enable");
endmodule

// *** sim/rid_partner.sv ***
`timescale 1ns/10ps
// ************************************************************
// reset pushbutton with contact chatter
// ************************************************************
module rid_partner (
    input wire logic aclk,
    input wire logic press_req,
    input wire logic [1:0] bounce,
    output logic reset_button
);
    logic last_q = 1'b0;
    logic [1:0] cnt_q = 2'h0;
    logic btn_q = 1'b0;

    assign reset_button = btn_q;

    // a real contact chatters after each change; the design must
    // not turn that into several events
    always @(posedge aclk)
    begin
        last_q <= press_req;
        if (press_req != last_q)
            cnt_q <= bounce;
        else if (cnt_q != 2'h0)
            cnt_q <= cnt_q - 2'h1;
        btn_q <= (cnt_q != 2'h0) ? ~btn_q : last_q;
    end
endmodule

// *** sim/restart_interlock_status_display_bench.sv ***
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
        end \
    end

module restart_interlock_status_display_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [5:0] awaddr = 6'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [5:0] araddr = 6'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic beam_clear = 1'b1;
    logic fault = 1'b0;
    logic press_req = 1'b0;
    logic [1:0] bounce = 2'h0;
    logic [1:0] align_level = 2'h0;
    logic awready, wready, bvalid, arready, rvalid, reset_button;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic switch_out, reset_lamp, led_red, led_green, seg_dp, irq;
    logic [6:0] seg;
    logic [31:0] rdat;
    logic [1:0] rs;
    int errors = 0;
    int checks_done = 0;
    int seed = 98930;
    int n;
    logic [31:0] ctrl_tab [4] = '{32'h001, 32'h081, 32'h101, 32'h009};
    logic [6:0] code_tab [4] = '{rid_pkg::SEG_U, rid_pkg::SEG_C1,
        rid_pkg::SEG_C2, rid_pkg::SEG_H};
    logic [6:0] align_tab [4] = '{rid_pkg::SEG_BLANK, rid_pkg::SEG_TWO,
        rid_pkg::SEG_ONE, rid_pkg::SEG_ZERO};

    always #5 aclk = ~aclk;

    rid_top #(
        .DEBOUNCE_CYC(4),
        .STARTUP_CYC(20)
    ) u_dut (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid),
        .s_axi_awready(awready),
        .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid),
        .s_axi_wready(wready),
        .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid),
        .s_axi_bready(bready),
        .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid),
        .s_axi_arready(arready),
        .s_axi_rdata(rdata),
        .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid),
        .s_axi_rready(rready),
        .beam_clear(beam_clear),
        .fault(fault),
        .reset_button(reset_button),
        .align_level(align_level),
        .switch_out(switch_out),
        .reset_lamp(reset_lamp),
        .led_red(led_red),
        .led_green(led_green),
        .seg(seg),
        .seg_dp(seg_dp),
        .irq(irq)
    );

    rid_partner u_btn (
        .aclk(aclk),
        .press_req(press_req),
        .bounce(bounce),
        .reset_button(reset_button)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [6:0] rot7(input logic [6:0] s);
        return {s[6], s[2:0], s[5:3]};
    endfunction

    function automatic logic [4:0] name_exp(input logic [4:0] v);
        return (v > rid_pkg::NAME_MAX) ? rid_pkg::NAME_MAX : v;
    endfunction

    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask

    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask

    task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic bus_rd(input logic [5:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rdat = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic lamps(input logic sw, input logic lp,
        input logic rd, input logic gn);
        `CHK("switch_out", sw, switch_out)
        `CHK("reset_lamp", lp, reset_lamp)
        `CHK("led_red", rd, led_red)
        `CHK("led_green", gn, led_green)
    endtask

    task automatic btn(input logic p);
        @(posedge aclk);
        press_req <= p;
        cyc(14);
    endtask

    task automatic beam(input logic c);
        @(posedge aclk);
        beam_clear <= c;
        cyc(8);
    endtask

    task automatic flt(input logic f);
        @(posedge aclk);
        fault <= f;
        cyc(8);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // red must track the outputs in the very same cycle
    always @(negedge aclk)
        if (aresetn === 1'b1)
            `CHK("red_vs_out", ~switch_out, led_red)

    initial
    begin
        #200000;
        errors++;
        stop_test();
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial
    begin
        for (int k = 0; k < 4; k++)
        begin
            @(posedge aclk);
            aresetn <= 1'b0;
            cyc(4);
            lamps(1'b0, 1'b0, 1'b1, 1'b0);
            aresetn <= 1'b1;
            bus_rd(rid_pkg::ADDR_CTRL);
            `CHK("ctrl_rst", 32'h001, rdat)
            bus_wr(rid_pkg::ADDR_CTRL, ctrl_tab[k]);
            cyc(2);
            `CHK("seg_start", code_tab[k], seg)
            cyc(25);
            `CHK("seg_later", rid_pkg::SEG_BLANK, seg)
        end
        lamps(1'b0, 1'b1, 1'b1, 1'b0);
        done("startup");

        bus_wr(rid_pkg::ADDR_MASK, 32'h1);
        btn(1'b1);
        lamps(1'b0, 1'b1, 1'b1, 1'b0);
        btn(1'b0);
        lamps(1'b1, 1'b0, 1'b0, 1'b1);
        bus_rd(rid_pkg::ADDR_STAT);
        `CHK("stat_on", 5'h12, rdat[4:0])
        bus_rd(rid_pkg::ADDR_IRQ);
        `CHK("irq_reset", 1'b1, rdat[2])
        cyc(2);
        `CHK("irq_idle", 1'b0, irq)
        beam(1'b0);
        lamps(1'b0, 1'b1, 1'b1, 1'b0);
        `CHK("irq_break", 1'b1, irq)
        bus_rd(rid_pkg::ADDR_IRQ);
        `CHK("irq_stat", 1'b1, rdat[0])
        cyc(2);
        `CHK("irq_clr", 1'b0, irq)
        beam(1'b1);
        lamps(1'b0, 1'b1, 1'b1, 1'b0);
        done("interlock");

        bus_wr(rid_pkg::ADDR_CTRL, 32'h003);
        btn(1'b1);
        lamps(1'b1, 1'b0, 1'b0, 1'b1);
        btn(1'b0);
        flt(1'b1);
        lamps(1'b0, 1'b1, 1'b1, 1'b0);
        flt(1'b0);
        lamps(1'b0, 1'b1, 1'b1, 1'b0);
        n = 1 + $unsigned($random(seed)) % 2;
        @(posedge aclk);
        press_req <= 1'b1;
        cyc(n);
        press_req <= 1'b0;
        cyc(14);
        lamps(1'b0, 1'b1, 1'b1, 1'b0);
        bounce <= 2'(1 + $unsigned($random(seed)) % 3);
        btn(1'b1);
        lamps(1'b1, 1'b0, 1'b0, 1'b1);
        btn(1'b0);
        done("fault_press");

        bus_wr(rid_pkg::ADDR_CTRL, 32'h000);
        beam(1'b0);
        lamps(1'b0, 1'b0, 1'b1, 1'b0);
        beam(1'b1);
        lamps(1'b1, 1'b0, 1'b0, 1'b1);
        done("no_interlock");

        bus_wr(rid_pkg::ADDR_CTRL, 32'h010);
        cyc(2);
        `CHK("seg_red", rid_pkg::SEG_R, seg)
        `CHK("dp_up", 1'b1, seg_dp)
        bus_wr(rid_pkg::ADDR_CTRL, 32'h014);
        cyc(2);
        `CHK("seg_rot", rot7(rid_pkg::SEG_R), seg)
        `CHK("dp_rot", 1'b0, seg_dp)
        bus_rd(rid_pkg::ADDR_SEG);
        `CHK("seg_reg", {1'b0, rot7(rid_pkg::SEG_R)}, rdat[7:0])
        bus_wr(rid_pkg::ADDR_CTRL, 32'h010);
        for (int lv = 1; lv < 4; lv++)
        begin
            @(posedge aclk);
            align_level <= 2'(lv);
            cyc(6);
            `CHK("seg_align", align_tab[lv], seg)
        end
        @(posedge aclk);
        align_level <= 2'h0;
        bus_wr(rid_pkg::ADDR_CTRL, 32'h060);
        cyc(2);
        `CHK("seg_test", rid_pkg::SEG_ZERO, seg)
        done("display");

        for (int i = 0; i < 6; i++)
        begin
            n = (i == 0) ? 22 : (i == 1) ? 23 : $unsigned($random(seed)) % 32;
            bus_rd(rid_pkg::ADDR_IRQ);
            bus_wr(rid_pkg::ADDR_NAME_LEN, 32'(n));
            bus_rd(rid_pkg::ADDR_NAME_LEN);
            `CHK("name_len", name_exp(5'(n)), rdat[4:0])
            bus_rd(rid_pkg::ADDR_IRQ);
            `CHK("name_trunc", (n > 22), rdat[3])
        end
        bus_wr(6'h18, 32'h5);
        `CHK("wr_unmapped", 2'b10, rs)
        bus_rd(6'h18);
        `CHK("rd_unmapped", 2'b10, rs)
        done("registers");
        stop_test();
    end
endmodule
